// file: dccu_core.sv
// Dual capture/compare unit: four timers, 32 channels, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

module dccu_core
  import dccu_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Channel pins and count inputs
  input  wire logic [31:0] cc_in,
  input  wire logic [1:0]  cnt_in,
  input  wire logic        ext_timer_six_ovf,
  output var  logic [31:0] cc_out,
  output var  logic [31:0] cc_oe,
  // Interrupt
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Prescaler tap for a 3-bit input select code
  function automatic logic presc_hit(input logic [PRESC_W-1:0] cnt,
                                     input logic [2:0]         sel);
    logic [PRESC_W:0] m;
    m = (PRESC_BASE << sel) - 11'h001;
    return (cnt & m[PRESC_W-1:0]) == m[PRESC_W-1:0];
  endfunction

  // Compare modes that watch the timer
  function automatic logic is_cmp(input dccu_mode_t m);
    return (m == CC_CMP0) || (m == CC_CMP1) || (m == CC_CMP2) ||
           (m == CC_CMP3) || (m == CC_DOUBLE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [TMR_W-1:0]   tmr [NUM_TMR];
  logic [TMR_W-1:0]   rld [NUM_TMR];
  dccu_tctl_t         tctl [NUM_TMR];
  logic [TMR_W-1:0]   ccv [NUM_CH];
  dccu_chcfg_t        chc [NUM_CH];
  logic [TMR_W-1:0]   cap_val [NUM_CH];
  logic [PRESC_W-1:0] presc;
  logic [NUM_TMR-1:0] tick, ovf, tick_d, ovf_d;
  logic [33:0]        in_s1, in_s2, in_s3, in_rise, in_fall;
  logic [NUM_CH-1:0]  done, cap, hit, ev;
  logic [NUM_CH-1:0]  next_done, next_pin, next_oe;
  logic [31:0]        stat, mask, next_stat, rd_mux, unit_rd;
  logic               wr_pend, rd_pend;
  logic [9:0]         wr_addr, rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic       bus_take, wr_unit;
  logic [7:0] wr_off;
  logic [4:0] wr_ch, rd_ch;
  logic [1:0] wr_t, rd_t;
  logic       we_tcnt, we_trld, we_tctl, we_chv, we_chc, we_stat, we_mask;

  // Address phase qualify and write-target decode
  assign bus_take = hsel & htrans[1] & hready;
  assign wr_unit  = wr_pend & ~wr_addr[9];
  assign wr_off   = wr_addr[7:0];
  assign wr_ch    = {wr_addr[8], wr_addr[5:2]};
  assign wr_t     = {wr_addr[8], wr_addr[2]};
  assign we_tcnt  = wr_unit & (wr_off[7:3] == OFF_TCNT[7:3]);
  assign we_trld  = wr_unit & (wr_off[7:3] == OFF_TRLD[7:3]);
  assign we_tctl  = wr_unit & (wr_off[7:3] == OFF_TCTL[7:3]);
  assign we_chv   = wr_unit & (wr_off[7:6] == OFF_CHV[7:6]);
  assign we_chc   = wr_unit & (wr_off[7:6] == OFF_CHC[7:6]);
  assign we_stat  = wr_pend & (wr_addr == OFF_IRQ_STAT);
  assign we_mask  = wr_pend & (wr_addr == OFF_IRQ_MASK);

  // Bus phase tracking; reads take one wait state so writes settle first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      wr_addr   <= 10'h000;
      rd_addr   <= 10'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end
    else
    begin
      wr_pend   <= bus_take & hwrite;
      rd_pend   <= bus_take & ~hwrite;
      hreadyout <= ~(bus_take & ~hwrite);
      if (bus_take)
      begin
        wr_addr <= haddr[9:0];
        rd_addr <= haddr[9:0];
      end
      if (rd_pend)
        hrdata <= rd_mux;
    end
  end

  // Read data select; unmapped addresses read zero
  assign rd_ch   = {rd_addr[8], rd_addr[5:2]};
  assign rd_t    = {rd_addr[8], rd_addr[2]};
  assign unit_rd = (rd_addr[7:3] == OFF_TCNT[7:3]) ? {16'h0000, tmr[rd_t]} :
                   (rd_addr[7:3] == OFF_TRLD[7:3]) ? {16'h0000, rld[rd_t]} :
                   (rd_addr[7:3] == OFF_TCTL[7:3]) ? {26'h0, tctl[rd_t]} :
                   (rd_addr[7:6] == OFF_CHV[7:6])  ? {16'h0000, ccv[rd_ch]} :
                   (rd_addr[7:6] == OFF_CHC[7:6])  ? {26'h0, chc[rd_ch]} :
                   32'h00000000;
  assign rd_mux  = !rd_addr[9]                ? unit_rd     :
                   (rd_addr == OFF_IRQ_STAT) ? stat        :
                   (rd_addr == OFF_IRQ_MASK) ? mask        :
                   (rd_addr == OFF_PIN_OUT)  ? cc_out      :
                   (rd_addr == OFF_PIN_IN)   ? in_s2[31:0] :
                   32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detect

  // Stage one feeds stage two only; edges judged on stages two and three
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_s1 <= 34'h000000000;
      in_s2 <= 34'h000000000;
      in_s3 <= 34'h000000000;
    end
    else
    begin
      in_s1 <= {cnt_in, cc_in};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  assign in_rise = in_s2 & ~in_s3;
  assign in_fall = ~in_s2 & in_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Time bases

  // Free-running prescaler shared by all four timers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      presc <= 10'h000;
    else
      presc <= presc + 10'h001;
  end

  // Count enable per timer from the selected source
  for (genvar t = 0; t < NUM_TMR; t++)
  begin : g_tick
    logic src_tick;
    always_comb
    begin
      case (tctl[t].src)
        SRC_PRESC: src_tick = presc_hit(presc, tctl[t].isel);
        SRC_T6:    src_tick = ext_timer_six_ovf;
        SRC_EXT:   src_tick = ((t % 2) == 0) ? in_rise[32 + t / 2] : 1'b0;
        default:   src_tick = 1'b0;
      endcase
    end
    assign tick[t] = tctl[t].run & src_tick;
    assign ovf[t]  = tick[t] & (tmr[t] == TMR_MAX);
  end

  // Timer, reload and control registers; software count write wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int t = 0; t < NUM_TMR; t++)
      begin
        tmr[t]  <= 16'h0000;
        rld[t]  <= 16'h0000;
        tctl[t] <= TCTL_RST;
      end
      tick_d <= 4'h0;
      ovf_d  <= 4'h0;
    end
    else
    begin
      for (int t = 0; t < NUM_TMR; t++)
      begin
        if (we_tcnt && wr_t == 2'(t))
          tmr[t] <= hwdata[15:0];
        else if (ovf[t])
          tmr[t] <= rld[t];
        else if (tick[t])
          tmr[t] <= tmr[t] + 16'h0001;
        if (we_trld && wr_t == 2'(t))
          rld[t] <= hwdata[15:0];
        if (we_tctl && wr_t == 2'(t))
          tctl[t] <= hwdata[5:0];
      end
      tick_d <= tick;
      ovf_d  <= ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam logic [4:0] CI      = 5'(c);
    localparam bit         HAS_OUT = (c < NOOUT_FIRST) || (c > NOOUT_LAST);
    localparam bit         LOW     = (c % CH_PER_UNIT) < PAIR_DIST;
    logic [1:0] tix;
    logic       per_end, live_done, first, part_hit;
    logic       nd, np, ne, no;

    // Unit comes from the channel number, timer from the config
    assign tix        = {CI[4], chc[c].tsel};
    assign cap_val[c] = tmr[tix];
    assign per_end    = ovf_d[tix];
    assign live_done  = per_end ? 1'b0 : done[c];
    assign first      = hit[c] & ~live_done;

    // Match on the cycle after the assigned timer moved
    assign hit[c] = is_cmp(chc[c].mode) & tick_d[tix] & (tmr[tix] == ccv[c]);
    assign cap[c] = (chc[c].mode == CC_CAPTURE) &
                    ((chc[c].edge_rise & in_rise[c]) |
                     (chc[c].edge_fall & in_fall[c]));

    // Partner eight channels up joins this pin in double mode
    if (LOW)
    begin : g_pair
      assign part_hit = hit[c + PAIR_DIST] & (chc[c + PAIR_DIST].mode == CC_DOUBLE);
    end
    else
    begin : g_nopair
      assign part_hit = 1'b0;
    end

    // Mode actions on pin, period flag and event
    always_comb
    begin
      nd = live_done;
      np = cc_out[c];
      ne = 1'b0;
      no = 1'b0;
      case (chc[c].mode)
        CC_CAPTURE: ne = cap[c];
        CC_CMP0:    ne = hit[c];
        CC_CMP1:
        begin
          ne = hit[c];
          np = cc_out[c] ^ hit[c];
          no = 1'b1;
        end
        CC_CMP2:
        begin
          ne = first;
          nd = live_done | hit[c];
        end
        CC_CMP3:
        begin
          ne = first;
          nd = live_done | hit[c];
          np = first ? 1'b1 : (per_end ? 1'b0 : cc_out[c]);
          no = 1'b1;
        end
        CC_DOUBLE:
        begin
          ne = hit[c];
          if (LOW)
          begin
            np = cc_out[c] ^ (hit[c] | part_hit);
            no = 1'b1;
          end
        end
        default:
        begin
          nd = 1'b0;
        end
      endcase
    end

    // Channels without a compare output never drive their pin
    assign next_done[c] = nd;
    assign next_pin[c]  = HAS_OUT ? np : 1'b0;
    assign next_oe[c]   = HAS_OUT ? no : 1'b0;
    assign ev[c]        = ne;
  end

  // Channel values and configs; a capture beats a software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        ccv[c] <= 16'h0000;
        chc[c] <= CHC_RST;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (cap[c])
          ccv[c] <= cap_val[c];
        else if (we_chv && wr_ch == 5'(c))
          ccv[c] <= hwdata[15:0];
        if (we_chc && wr_ch == 5'(c))
          chc[c] <= {hwdata[5:4], dccu_mode_t'(hwdata[3:1]), hwdata[0]};
      end
    end
  end

  // Pin, enable and once-per-period flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      done   <= 32'h00000000;
      cc_out <= 32'h00000000;
      cc_oe  <= 32'h00000000;
    end
    else
    begin
      done   <= next_done;
      cc_out <= next_pin;
      cc_oe  <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Write one to clear; a new event in the same cycle wins
  assign next_stat = (stat & ~(we_stat ? hwdata : 32'h00000000)) | ev;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat <= 32'h00000000;
      mask <= MASK_RST;
      irq  <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      if (we_mask)
        mask <= hwdata;
      irq  <= |(stat & mask);
    end
  end

endmodule

`default_nettype wire

// file: dccu_pkg.sv
// Constants, register map and types of the dual capture/compare unit
package dccu_pkg;

  // Structure
  localparam int NUM_UNITS   = 2;
  localparam int CH_PER_UNIT = 16;
  localparam int NUM_CH      = 32;
  localparam int NUM_TMR     = 4;
  localparam int TMR_W       = 16;
  localparam int PRESC_W     = 10;
  localparam int PAIR_DIST   = 8;
  localparam int NOOUT_FIRST = 24;
  localparam int NOOUT_LAST  = 27;

  // Timing: code 000 divides by 8, each code step doubles it
  localparam logic [PRESC_W:0] PRESC_BASE = 11'h008;
  localparam logic [TMR_W-1:0] TMR_MAX    = 16'hFFFF;

  // Byte offsets inside one unit (unit b adds UNIT_STRIDE)
  localparam logic [9:0] UNIT_STRIDE = 10'h100;
  localparam logic [7:0] OFF_TCNT    = 8'h00;
  localparam logic [7:0] OFF_TRLD    = 8'h08;
  localparam logic [7:0] OFF_TCTL    = 8'h10;
  localparam logic [7:0] OFF_CHV     = 8'h40;
  localparam logic [7:0] OFF_CHC     = 8'h80;

  // Byte offsets of the shared registers
  localparam logic [9:0] OFF_IRQ_STAT = 10'h200;
  localparam logic [9:0] OFF_IRQ_MASK = 10'h204;
  localparam logic [9:0] OFF_PIN_OUT  = 10'h208;
  localparam logic [9:0] OFF_PIN_IN   = 10'h20C;

  // Timer clock sources
  localparam logic [1:0] SRC_PRESC = 2'h0;
  localparam logic [1:0] SRC_T6    = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;

  // Reset values
  localparam logic [5:0]  TCTL_RST = 6'h00;
  localparam logic [5:0]  CHC_RST  = 6'h00;
  localparam logic [31:0] MASK_RST = 32'h00000000;

  // Channel operating modes
  typedef enum logic [2:0] {
    CC_OFF, CC_CAPTURE, CC_CMP0, CC_CMP1, CC_CMP2, CC_CMP3, CC_DOUBLE
  } dccu_mode_t;

  // Timer control word: [5] run, [4:3] source, [2:0] input select
  typedef struct packed {
    logic       run;
    logic [1:0] src;
    logic [2:0] isel;
  } dccu_tctl_t;

  // Channel config word: [5] falling, [4] rising, [3:1] mode, [0] timer
  typedef struct packed {
    logic       edge_fall;
    logic       edge_rise;
    dccu_mode_t mode;
    logic       tsel;
  } dccu_chcfg_t;

endpackage

// file: dccu_core_sva.sv
// Port checker for the dual capture/compare unit
`timescale 1ns/1ps
`default_nettype none

module dccu_core_sva (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins and interrupt
  input wire logic [31:0] cc_out,
  input wire logic [31:0] cc_oe,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Transfer taken at this edge
  wire take = hsel && htrans[1] && hready;

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  a_rdata_hold: assert property ($changed(hrdata) |-> hreadyout && !$past(hreadyout))
    else $error("read data moved outside a read");
  a_noout_level: assert property (cc_out[27:24] == 4'h0)
    else $error("output level on input-only channel");
  a_noout_drive: assert property (cc_oe[27:24] == 4'h0)
    else $error("drive on input-only channel");
  a_reset_quiet: assert property ($rose(hresetn) |-> hreadyout && !irq && cc_oe == 32'h0)
    else $error("outputs busy after reset");
endmodule

bind dccu_core dccu_core_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cc_out(cc_out), .cc_oe(cc_oe), .irq(irq));

`default_nettype wire

// file: dccu_pins.sv
// Far-side pin model: capture sources, count pulses, timer six overflow
`timescale 1ns/1ps
`default_nettype none

module dccu_pins (
  // Clock
  input  wire logic        hclk,
  // Compare side of the pins
  input  wire logic [31:0] cc_out,
  input  wire logic [31:0] cc_oe,
  // Toward the unit
  output wire logic [31:0] cc_in,
  output var  logic [1:0]  cnt_in,
  output var  logic        ext_timer_six_ovf
);
  logic [31:0] drv;

  // Unit drives where enabled, far side elsewhere
  assign cc_in = (cc_oe & cc_out) | (~cc_oe & drv);

  initial
  begin
    drv = 32'h0;
    cnt_in = 2'h0;
    ext_timer_six_ovf = 1'b0;
  end

  // Level held past the input synchroniser
  task automatic set_pin(input int c, input logic v);
    @(posedge hclk);
    drv[c] <= v;
    repeat (4) @(posedge hclk);
  endtask

  // Count pulses, two cycles high and three low
  task automatic cnt_pulse(input int u, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      cnt_in[u] <= 1'b1;
      repeat (2) @(posedge hclk);
      cnt_in[u] <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask

  // One-cycle overflow pulses
  task automatic six_pulse(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      ext_timer_six_ovf <= 1'b1;
      @(posedge hclk);
      ext_timer_six_ovf <= 1'b0;
      @(posedge hclk);
    end
  endtask
endmodule

`default_nettype wire

// file: tb_dccu_core.sv
// Self-checking bench for the dual capture/compare unit
`timescale 1ns/1ps
`default_nettype none

module tb_dccu_core
  import dccu_pkg::*;
;
  localparam logic [31:0] STAT = {22'h0, OFF_IRQ_STAT};
  localparam logic [31:0] MASK = {22'h0, OFF_IRQ_MASK};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, cc_in, cc_out, cc_oe, rd;
  logic [1:0]  cnt_in;
  logic        hreadyout, hresp, irq, six, hit;
  logic [15:0] x, y, v;
  logic [5:0]  cf;
  int          n_fail = 0, checked = 0, cyc = 0, k;
  int          chs[6] = '{3, 5, 0, 25, 6, 7};
  dccu_mode_t  ms[6] = '{CC_CMP1, CC_CMP3, CC_DOUBLE, CC_CMP1, CC_CMP0, CC_CMP2};

  always #20 hclk = ~hclk;

  dccu_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cc_in(cc_in),
    .cnt_in(cnt_in), .ext_timer_six_ovf(six), .cc_out(cc_out), .cc_oe(cc_oe), .irq(irq));
  dccu_pins u_pins (.hclk(hclk), .cc_out(cc_out), .cc_oe(cc_oe), .cc_in(cc_in),
    .cnt_in(cnt_in), .ext_timer_six_ovf(six));

  task automatic print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One single AHB transfer
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d, rd);
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, exp);
    xfer(1'b0, a, 32'h0, rd);
    chk(nm, rd, exp);
  endtask

  function automatic logic [31:0] ta(input int u, t, input logic [7:0] off);
    return 32'(u * 256 + 4 * t) + {24'h0, off};
  endfunction

  function automatic logic [31:0] ca(input int c, input logic [7:0] off);
    return 32'(c / 16 * 256 + 4 * (c % 16)) + {24'h0, off};
  endfunction

  // Pin changes in 512 cycles at a 128-cycle timer period
  function automatic int exp_tog(input int c, input dccu_mode_t m);
    if (c >= NOOUT_FIRST && c <= NOOUT_LAST)
      return 0;
    return (m == CC_CMP1) ? 4 : (m == CC_CMP3 || m == CC_DOUBLE) ? 8 : 0;
  endfunction

  task automatic tmr(input int u, t, input logic [15:0] c, r, input logic [5:0] ctl);
    wr(ta(u, t, OFF_TRLD), {16'h0, r});
    wr(ta(u, t, OFF_TCTL), {26'h0, ctl});
    wr(ta(u, t, OFF_TCNT), {16'h0, c});
  endtask

  task automatic chan(input int c, input logic [5:0] cfg, input logic [15:0] val);
    wr(ca(c, OFF_CHV), {16'h0, val});
    wr(ca(c, OFF_CHC), {26'h0, cfg});
  endtask

  task automatic count_tog(input int c, output int n);
    logic p;
    n = 0;
    p = cc_out[c];
    repeat (512)
    begin
      @(posedge hclk);
      if (cc_out[c] !== p)
        n++;
      p = cc_out[c];
    end
  endtask

  // Hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  initial
  begin
    rd = $urandom(18);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place, reload readback
    rdc("mask", MASK, MASK_RST);
    rdc("tctl", ta(1, 1, OFF_TCTL), {26'h0, TCTL_RST});
    wr(32'h0000_03F0, 32'hFFFF_FFFF);
    rdc("unmapped", 32'h0000_03F0, 32'h0);
    for (int u = 0; u < 4; u++)
    begin
      x = 16'($urandom);
      wr(ta(u / 2, u % 2, OFF_TRLD), {16'h0, x});
      rdc("reload", ta(u / 2, u % 2, OFF_TRLD), {16'h0, x});
    end
    $display("test regs done");
    // Capture on each edge choice, from either timer
    k = $urandom_range(31, 0);
    x = 16'($urandom) | 16'h1;
    y = 16'($urandom) | 16'h2;
    tmr(k / 16, 0, x, 16'h0, 6'h0);
    tmr(k / 16, 1, y, 16'h0, 6'h0);
    for (int e = 1; e < 4; e++)
      for (int l = 1; l >= 0; l--)
      begin
        cf = {e[1:0], CC_CAPTURE, 1'(l ^ e[0])};
        chan(k, cf, 16'h0);
        rdc("cfg", ca(k, OFF_CHC), {26'h0, cf});
        wr(STAT, 32'hFFFF_FFFF);
        u_pins.set_pin(k, l[0]);
        hit = l[0] ? e[0] : e[1];
        v = hit ? (cf[0] ? y : x) : 16'h0;
        rdc("capture", ca(k, OFF_CHV), {16'h0, v});
        rdc("cap_flag", STAT, 32'(hit) << k);
      end
    // Interrupt masked, enabled, cleared
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(MASK, 32'h1 << k);
    repeat (2) @(posedge hclk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(STAT, 32'h1 << k);
    repeat (2) @(posedge hclk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rdc("w1c", STAT, 32'h0);
    wr(MASK, 32'h0);
    chan(k, 6'h0, 16'h0);
    $display("test capture done");
    // Every input select code
    for (int c = 0; c < 8; c++)
    begin
      tmr(0, 0, 16'h0, 16'h0, {1'b1, SRC_PRESC, 3'(c)});
      repeat (4 * (8 << c)) @(posedge hclk);
      xfer(1'b0, ta(0, 0, OFF_TCNT), 32'h0, rd);
      chk("presc", 32'(rd >= 3 && rd <= 5), 32'h1);
    end
    $display("test prescaler done");
    // Timer six, count pin, reload on overflow
    x = 16'($urandom_range(16'hFF00, 0));
    tmr(0, 0, 16'hFFFF, x, {1'b1, SRC_T6, 3'h0});
    u_pins.six_pulse(1);
    rdc("reload_load", ta(0, 0, OFF_TCNT), {16'h0, x});
    u_pins.six_pulse(6);
    rdc("six_count", ta(0, 0, OFF_TCNT), {16'h0, x + 16'h6});
    k = $urandom_range(9, 1);
    tmr(1, 0, 16'h0, 16'h0, {1'b1, SRC_EXT, 3'h0});
    u_pins.cnt_pulse(1, k);
    rdc("ext_count", ta(1, 0, OFF_TCNT), 32'(k));
    $display("test sources done");
    // Periodic compare modes, 16 ticks of 8 cycles a period
    for (int u = 0; u < 2; u++)
      tmr(u, 0, 16'hFFF0, 16'hFFF0, {1'b1, SRC_PRESC, 3'h0});
    for (int i = 0; i < 6; i++)
    begin
      v = 16'hFFF0 + 16'($urandom_range(15, 1));
      chan(chs[i], {2'h0, ms[i], 1'b0}, v);
      if (ms[i] == CC_DOUBLE)
        chan(chs[i] + PAIR_DIST, {2'h0, CC_DOUBLE, 1'b0}, {v[15:4], ~v[3:0]});
      repeat (128) @(posedge hclk);
      count_tog(chs[i], k);
      chk("toggles", 32'(k), 32'(exp_tog(chs[i], ms[i])));
      chk("drive", {31'h0, cc_oe[chs[i]]}, 32'(exp_tog(chs[i], ms[i]) != 0));
      chan(chs[i], 6'h0, 16'h0);
      chan(chs[i] + PAIR_DIST, 6'h0, 16'h0);
    end
    // Second match in one period: repeats in mode 0, not in mode 2
    for (int i = 0; i < 2; i++)
    begin
      chan(6, {2'h0, (i == 0) ? CC_CMP0 : CC_CMP2, 1'b0}, 16'h1234);
      for (int j = 0; j < 2; j++)
      begin
        tmr(0, 0, 16'h1233, 16'h0, {1'b1, SRC_T6, 3'h0});
        wr(STAT, 32'hFFFF_FFFF);
        u_pins.six_pulse(1);
        repeat (3) @(posedge hclk);
        rdc("repeat", STAT, 32'(j == 0 || i == 0) << 6);
      end
    end
    $display("test compare done");
    print_verdict();
  end
endmodule

`default_nettype wire
